// [hw/cwg_top.sv]
// Compare waveform generator: counter, compare channels, waveform outputs, APB registers
// Functional notes
// RULE_01: Counter compared against every channel each tick, channels independent.
// RULE_02: Match flag sets at the next counter clock tick, not immediately.
// RULE_03: Match raises interrupt if unmasked and event if event output enabled.
// RULE_04: Each channel match also pulses that channel's DMA request.
// RULE_05: Seven waveform modes selectable; illegal mode code is ignored.
// RULE_06: Match frequency takes top from compare zero, others from period.
// RULE_07: Dual-slope modes load buffered top and compare values at zero.
// RULE_08: Single-slope modes load buffers on wrap, overflow, underflow or retrigger.
// RULE_09: Frequency modes toggle output on match; overflow at top up, zero down.
// RULE_10: Software picks the mode; set invert bit drives that output inverted.
// RULE_11: Dual-slope counts zero to top and back, events per chosen variant.
`timescale 1ns/1ps
`include "cwg_params.svh"
module cwg_top (
  input wire logic clock_in, // System clock, 25 MHz
  input wire logic reset_n_in, // Async reset, active low
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB direction, high for write
  input wire logic [7:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error, unmapped address
  output logic [3:0] waveform_output_out, // Waveform outputs to pins
  output logic [3:0] match_event_out, // Match event pulses
  output logic overflow_event_out, // Overflow event pulse
  output logic [3:0] dma_request_out, // Per-channel DMA request pulses
  output logic interrupt_out, // Level interrupt
  output cwg_pkg::cwg_cnt_t count_out // Running counter value
);
  import cwg_pkg::*;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= `CWG_OFF_PRESC);
  endfunction

  function automatic logic [1:0] cc_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `CWG_OFF_CC0;
    cc_index = d[3:2];
  endfunction

  // Register state
  logic en_reg, en_next;
  cwg_mode_t mode_reg, mode_next;
  logic down_reg, down_next;
  logic [3:0] inv_reg, inv_next;
  logic [4:0] mask_reg, mask_next;
  logic [4:0] stat_reg, stat_next;
  logic [4:0] evctrl_reg, evctrl_next;
  cwg_cnt_t per_buf_reg, per_buf_next;
  cwg_cnt_t per_act_reg, per_act_next;
  cwg_cnt_t cc_buf_reg [4];
  cwg_cnt_t cc_buf_next [4];
  cwg_cnt_t cc_act_reg [4];
  cwg_cnt_t cc_act_next [4];
  cwg_presc_t presc_reg, presc_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  // Counter and output state
  cwg_cnt_t count_reg, count_next;
  logic dir_reg, dir_next;
  logic [3:0] wave_reg, wave_next;
  logic [3:0] wo_reg, wo_next;
  logic [3:0] mev_reg, mev_next;
  logic ovf_reg, ovf_next;
  logic [3:0] dma_reg, dma_next;

  logic tick;
  logic setup_ph, access_ph, wr_acc, rd_stat;
  logic retrig, dual, single_down;
  logic update, ovf_hit;
  logic [3:0] match;
  cwg_cnt_t top_w;

  cwg_tick_div u_div (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .enable_in(en_reg),
    .divide_in(presc_reg),
    .tick_out(tick)
  );

  assign setup_ph = psel_in && !penable_in;
  assign access_ph = psel_in && penable_in;
  assign wr_acc = access_ph && pwrite_in && !err_reg;
  // Read clear hits only the bits that were captured for the reader
  assign rd_stat = access_ph && !pwrite_in && (paddr_in == `CWG_OFF_INTSTAT);
  assign retrig = wr_acc && (paddr_in == `CWG_OFF_CTRL) && pwdata_in[`CWG_CTRL_RETRIG];
  assign dual = (mode_reg == CWG_DUAL_SLOPE_TOP_EVENT_MODE) || (mode_reg == CWG_DUAL_SLOPE_ZERO_EVENT_MODE) ||
                (mode_reg == CWG_DUAL_SLOPE_BOTH_EVENT_MODE) || (mode_reg == CWG_DUAL_SLOPE_CRITICAL_MODE);
  assign single_down = !dual && down_reg;
  assign top_w = (mode_reg == CWG_MATCH_FREQUENCY_MODE) ? cc_act_reg[0] : per_act_reg; // RULE_06

  always_comb begin
    for (int i = 0; i < `CWG_CH_NUM; i++) begin
      match[i] = (count_reg == cc_act_reg[i]); // RULE_01
    end
  end

  // Register file next state
  always_comb begin
    en_next = en_reg;
    mode_next = mode_reg;
    down_next = down_reg;
    inv_next = inv_reg;
    mask_next = mask_reg;
    evctrl_next = evctrl_reg;
    per_buf_next = per_buf_reg;
    presc_next = presc_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    for (int i = 0; i < `CWG_CH_NUM; i++) begin
      cc_buf_next[i] = cc_buf_reg[i];
    end
    if (setup_ph) begin
      err_next = !is_mapped(paddr_in);
      rdata_next = 32'h0000_0000;
      unique case (paddr_in)
        `CWG_OFF_CTRL: begin
          rdata_next[`CWG_CTRL_EN] = en_reg;
          rdata_next[`CWG_CTRL_MODE_HI:`CWG_CTRL_MODE_LO] = mode_reg;
          rdata_next[`CWG_CTRL_DOWN] = down_reg;
        end
        `CWG_OFF_DRV: rdata_next[3:0] = inv_reg;
        `CWG_OFF_INTMASK: rdata_next[4:0] = mask_reg;
        `CWG_OFF_INTSTAT: rdata_next[4:0] = stat_reg;
        `CWG_OFF_EVCTRL: rdata_next[4:0] = evctrl_reg;
        `CWG_OFF_PERIOD: rdata_next[15:0] = per_buf_reg;
        `CWG_OFF_CC0, `CWG_OFF_CC1, `CWG_OFF_CC2, `CWG_OFF_CC3: begin
          rdata_next[15:0] = cc_buf_reg[cc_index(paddr_in)];
        end
        `CWG_OFF_COUNT: rdata_next[15:0] = count_reg;
        `CWG_OFF_PRESC: rdata_next[7:0] = presc_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (wr_acc) begin
      unique case (paddr_in)
        `CWG_OFF_CTRL: begin
          en_next = pwdata_in[`CWG_CTRL_EN];
          down_next = pwdata_in[`CWG_CTRL_DOWN];
          // Code 7 has no mode, so the old mode stays
          if (pwdata_in[`CWG_CTRL_MODE_HI:`CWG_CTRL_MODE_LO] != 3'h7) begin
            mode_next = cwg_mode_t'(pwdata_in[`CWG_CTRL_MODE_HI:`CWG_CTRL_MODE_LO]); // RULE_05
          end
        end
        `CWG_OFF_DRV: inv_next = pwdata_in[3:0]; // RULE_10
        `CWG_OFF_INTMASK: mask_next = pwdata_in[4:0];
        `CWG_OFF_EVCTRL: evctrl_next = pwdata_in[4:0];
        `CWG_OFF_PERIOD: per_buf_next = pwdata_in[15:0];
        `CWG_OFF_CC0, `CWG_OFF_CC1, `CWG_OFF_CC2, `CWG_OFF_CC3: begin
          cc_buf_next[cc_index(paddr_in)] = pwdata_in[15:0];
        end
        `CWG_OFF_PRESC: presc_next = pwdata_in[7:0];
        default: begin
        end
      endcase
    end
  end

  // Counter, buffers, flags and outputs next state
  always_comb begin
    count_next = count_reg;
    dir_next = dir_reg;
    update = 1'b0;
    ovf_hit = 1'b0;
    wave_next = wave_reg;
    mev_next = 4'h0;
    dma_next = 4'h0;
    ovf_next = 1'b0;
    per_act_next = per_act_reg;
    for (int i = 0; i < `CWG_CH_NUM; i++) begin
      cc_act_next[i] = cc_act_reg[i];
    end
    if (!en_reg) begin
      count_next = 16'h0000;
      dir_next = 1'b0;
      update = 1'b1;
    end else if (retrig) begin
      count_next = single_down ? top_w : 16'h0000;
      dir_next = 1'b0;
      update = 1'b1; // RULE_08
    end else if (tick) begin
      if (dual) begin
        if (!dir_reg) begin
          if (top_w == 16'h0000) begin
            count_next = 16'h0000;
          end else if (count_reg >= top_w) begin
            count_next = count_reg - 16'h0001;
            dir_next = 1'b1; // RULE_11
            ovf_hit = (mode_reg == CWG_DUAL_SLOPE_TOP_EVENT_MODE) || (mode_reg == CWG_DUAL_SLOPE_BOTH_EVENT_MODE);
          end else begin
            count_next = count_reg + 16'h0001;
          end
        end else if (count_reg <= 16'h0001) begin
          count_next = 16'h0000;
          dir_next = 1'b0; // RULE_11
          update = 1'b1; // RULE_07
          ovf_hit = (mode_reg != CWG_DUAL_SLOPE_TOP_EVENT_MODE);
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end else if (single_down) begin
        if (count_reg == 16'h0000) begin
          count_next = top_w;
          update = 1'b1; // RULE_08
          ovf_hit = 1'b1; // RULE_09
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end else if (count_reg >= top_w) begin
        count_next = 16'h0000;
        update = 1'b1; // RULE_08
        ovf_hit = 1'b1; // RULE_09
      end else begin
        count_next = count_reg + 16'h0001;
      end
      // The count seen here was loaded one tick earlier, so flags lag a tick
      for (int i = 0; i < `CWG_CH_NUM; i++) begin
        dma_next[i] = match[i]; // RULE_04
        mev_next[i] = match[i] && evctrl_reg[`CWG_ST_MC + i]; // RULE_03
        unique case (mode_reg)
          CWG_NORMAL_FREQUENCY_MODE, CWG_MATCH_FREQUENCY_MODE: begin
            if (match[i]) begin
              wave_next[i] = !wave_reg[i]; // RULE_09
            end
          end
          default: wave_next[i] = (count_reg < cc_act_reg[i]);
        endcase
      end
      ovf_next = ovf_hit && evctrl_reg[`CWG_ST_OVF];
    end
    if (update) begin
      per_act_next = per_buf_reg;
      for (int i = 0; i < `CWG_CH_NUM; i++) begin
        cc_act_next[i] = cc_buf_reg[i];
      end
    end
    wo_next = wave_next ^ inv_next; // RULE_10
    // A new event beats the read clear in the same cycle
    stat_next = stat_reg & ~(rd_stat ? rdata_reg[4:0] : 5'h00);
    stat_next = stat_next | {dma_next, ovf_hit}; // RULE_02
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_reg <= 1'b0;
      mode_reg <= CWG_NORMAL_FREQUENCY_MODE;
      down_reg <= 1'b0;
      inv_reg <= 4'h0;
      mask_reg <= 5'h00;
      stat_reg <= 5'h00;
      evctrl_reg <= 5'h00;
      per_buf_reg <= `CWG_RST_PERIOD;
      per_act_reg <= `CWG_RST_PERIOD;
      presc_reg <= `CWG_RST_PRESC;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      count_reg <= 16'h0000;
      dir_reg <= 1'b0;
      wave_reg <= 4'h0;
      wo_reg <= 4'h0;
      mev_reg <= 4'h0;
      ovf_reg <= 1'b0;
      dma_reg <= 4'h0;
      for (int i = 0; i < `CWG_CH_NUM; i++) begin
        cc_buf_reg[i] <= `CWG_RST_CC;
        cc_act_reg[i] <= `CWG_RST_CC;
      end
    end else begin
      en_reg <= en_next;
      mode_reg <= mode_next;
      down_reg <= down_next;
      inv_reg <= inv_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      evctrl_reg <= evctrl_next;
      per_buf_reg <= per_buf_next;
      per_act_reg <= per_act_next;
      presc_reg <= presc_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      count_reg <= count_next;
      dir_reg <= dir_next;
      wave_reg <= wave_next;
      wo_reg <= wo_next;
      mev_reg <= mev_next;
      ovf_reg <= ovf_next;
      dma_reg <= dma_next;
      for (int i = 0; i < `CWG_CH_NUM; i++) begin
        cc_buf_reg[i] <= cc_buf_next[i];
        cc_act_reg[i] <= cc_act_next[i];
      end
    end
  end

  assign prdata_out = rdata_reg;
  assign pready_out = access_ph;
  assign pslverr_out = access_ph && err_reg;
  assign waveform_output_out = wo_reg;
  assign match_event_out = mev_reg;
  assign overflow_event_out = ovf_reg;
  assign dma_request_out = dma_reg;
  assign interrupt_out = |(stat_reg & mask_reg); // RULE_03
  assign count_out = count_reg;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  property p_flag_next_tick;
    en_reg && !retrig && tick && match[0] |=> stat_reg[`CWG_ST_MC] && dma_request_out[0];
  endproperty
  a_flag_next_tick: assert property (p_flag_next_tick) else $error("match flag not set"); // RULE_02

  property p_chan3;
    en_reg && !retrig && tick && (count_reg == cc_act_reg[3]) |=> stat_reg[4];
  endproperty
  a_chan3: assert property (p_chan3) else $error("channel 3 compare missed"); // RULE_01

  property p_no_tick_no_dma;
    !tick |=> dma_request_out == 4'h0;
  endproperty
  a_no_tick_no_dma: assert property (p_no_tick_no_dma) else $error("dma without tick"); // RULE_04

  property p_event_out;
    match_event_out[1] |-> dma_request_out[1] && $past(evctrl_reg[2]);
  endproperty
  a_event_out: assert property (p_event_out) else $error("event without enabled match"); // RULE_03

  property p_irq;
    stat_reg[`CWG_ST_OVF] && mask_reg[`CWG_ST_OVF] |-> interrupt_out;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked flag gives no interrupt"); // RULE_03

  property p_mode_legal;
    mode_reg != 3'h7;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal mode held"); // RULE_05

  property p_match_frequency_mode_top;
    en_reg && mode_reg == CWG_MATCH_FREQUENCY_MODE && !dir_reg && !down_reg && !retrig |->
      count_reg <= cc_act_reg[0] || $past(count_reg) > cc_act_reg[0] || !$stable(cc_act_reg[0]);
  endproperty
  a_match_frequency_mode_top: assert property (p_match_frequency_mode_top) else $error("counter passed compare zero top"); // RULE_06

  property p_dual_update;
    en_reg && $past(en_reg) && dual && $stable(mode_reg) && $changed(per_act_reg) |->
      count_reg == 16'h0000;
  endproperty
  a_dual_update: assert property (p_dual_update) else $error("dual-slope update off zero"); // RULE_07

  property p_single_update;
    en_reg && $past(en_reg) && !dual && $stable(mode_reg) && $changed(per_act_reg) |->
      count_reg == 16'h0000 || count_reg == $past(top_w);
  endproperty
  a_single_update: assert property (p_single_update) else $error("single-slope update off wrap"); // RULE_08

  property p_toggle;
    en_reg && tick && !retrig && mode_reg == CWG_NORMAL_FREQUENCY_MODE && match[2] |=>
      wave_reg[2] != $past(wave_reg[2]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on match"); // RULE_09

  property p_invert;
    ##1 waveform_output_out == (wave_reg ^ inv_reg);
  endproperty
  a_invert: assert property (p_invert) else $error("output inversion wrong"); // RULE_10

  property p_dual_turn;
    en_reg && dual && tick && !retrig && !dir_reg && top_w != 16'h0000 && count_reg >= top_w
      |=> dir_reg ##1 !$rose(count_reg[0]) || dir_reg;
  endproperty
  a_dual_turn: assert property (p_dual_turn) else $error("dual-slope did not turn at top"); // RULE_11

  c_overflow: cover property (overflow_event_out);
  c_dual_zero: cover property (dual && dir_reg ##1 !dir_reg);
  c_irq: cover property ($rose(interrupt_out));
  c_read_clear: cover property (rd_stat && stat_reg != 5'h00);
endmodule

// [hw/cwg_params.svh]
// Register offsets, field positions, reset values and sizes of the compare waveform generator
`ifndef CWG_PARAMS_SVH
`define CWG_PARAMS_SVH

`define CWG_CNT_W 16
`define CWG_CH_NUM 4
`define CWG_ADDR_W 8
`define CWG_OFF_CTRL 8'h00
`define CWG_OFF_DRV 8'h04
`define CWG_OFF_INTMASK 8'h08
`define CWG_OFF_INTSTAT 8'h0c
`define CWG_OFF_EVCTRL 8'h10
`define CWG_OFF_PERIOD 8'h14
`define CWG_OFF_CC0 8'h18
`define CWG_OFF_CC1 8'h1c
`define CWG_OFF_CC2 8'h20
`define CWG_OFF_CC3 8'h24
`define CWG_OFF_COUNT 8'h28
`define CWG_OFF_PRESC 8'h2c
`define CWG_CTRL_EN 0
`define CWG_CTRL_MODE_LO 4
`define CWG_CTRL_MODE_HI 6
`define CWG_CTRL_DOWN 8
`define CWG_CTRL_RETRIG 9
`define CWG_ST_OVF 0
`define CWG_ST_MC 1
`define CWG_RST_PERIOD 16'hffff
`define CWG_RST_CC 16'h0000
`define CWG_RST_PRESC 8'h00

`endif

// [hw/cwg_pkg.sv]
// Types shared by the compare waveform generator files
package cwg_pkg;
  typedef enum logic [2:0] {
    CWG_NORMAL_FREQUENCY_MODE = 3'h0,
    CWG_MATCH_FREQUENCY_MODE = 3'h1,
    CWG_NORMAL_PWM_MODE = 3'h2,
    CWG_DUAL_SLOPE_TOP_EVENT_MODE = 3'h3,
    CWG_DUAL_SLOPE_ZERO_EVENT_MODE = 3'h4,
    CWG_DUAL_SLOPE_BOTH_EVENT_MODE = 3'h5,
    CWG_DUAL_SLOPE_CRITICAL_MODE = 3'h6
  } cwg_mode_t;
  typedef logic [15:0] cwg_cnt_t;
  typedef logic [7:0] cwg_presc_t;
endpackage

// [hw/cwg_tick_div.sv]
// Prescaler that makes the one-cycle counter clock tick
`timescale 1ns/1ps
module cwg_tick_div (
  input wire logic clock_in, // System clock
  input wire logic reset_n_in, // Async reset, active low
  input wire logic enable_in, // Counter running
  input wire cwg_pkg::cwg_presc_t divide_in, // Tick every divide_in+1 cycles
  output logic tick_out // One-cycle tick pulse
);
  import cwg_pkg::*;
  cwg_presc_t cnt_reg;
  cwg_presc_t cnt_next;
  logic tick_next;

  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!enable_in) begin
      cnt_next = 8'h00;
    end else if (cnt_reg >= divide_in) begin
      cnt_next = 8'h00;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_reg <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_out <= tick_next;
    end
  end
endmodule

// [bench/cwg_pin_load.sv]
// Pin controller model: takes the waveform levels onto pads and counts high time per pad
`timescale 1ns/1ps
module cwg_pin_load (
  input wire logic clock_in, // System clock
  input wire logic reset_n_in, // Async reset, active low
  input wire logic clear_in, // Restart the high-time counters
  input wire logic [3:0] waveform_output_in, // Levels from the generator
  output logic [3:0][15:0] high_cycles_out // Cycles each pad was seen high
);
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      high_cycles_out <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // The pad follows the level as driven, inversion already applied
        if (clear_in) begin
          high_cycles_out[i] <= 16'h0000;
        end else if (waveform_output_in[i] === 1'b1) begin
          high_cycles_out[i] <= high_cycles_out[i] + 16'h0001;
        end
      end
    end
  end
endmodule

// [bench/tb_top.sv]
// Self-checking testbench of the compare waveform generator
`timescale 1ns/1ps
`include "cwg_params.svh"
module tb_top;
  import cwg_pkg::*;
  logic clk, rst_n, psel, pen, pwr, pclr, prdy, perr, ovf_ev, irq, e;
  logic [7:0] pa;
  logic [31:0] pwd, prd, q;
  logic [3:0] wave, mev, dma;
  cwg_cnt_t cnt;
  logic [3:0][15:0] high;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  // Mode table: mode, count down, prescaler, overflow event spacing (both-event: top to zero)
  localparam int MD [9] = '{CWG_NORMAL_FREQUENCY_MODE, CWG_NORMAL_FREQUENCY_MODE, CWG_MATCH_FREQUENCY_MODE, CWG_NORMAL_PWM_MODE, CWG_DUAL_SLOPE_TOP_EVENT_MODE,
    CWG_DUAL_SLOPE_ZERO_EVENT_MODE, CWG_DUAL_SLOPE_BOTH_EVENT_MODE, CWG_DUAL_SLOPE_CRITICAL_MODE, CWG_NORMAL_FREQUENCY_MODE};
  localparam int DN [9] = '{0, 1, 0, 0, 0, 0, 0, 0, 0};
  localparam int PS [9] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
  localparam int GP [9] = '{5, 5, 3, 5, 8, 8, 3, 8, 10};

  cwg_top uut (
    .clock_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .waveform_output_out(wave),
    .match_event_out(mev), .overflow_event_out(ovf_ev), .dma_request_out(dma),
    .interrupt_out(irq), .count_out(cnt)
  );
  cwg_pin_load load (
    .clock_in(clk), .reset_n_in(rst_n), .clear_in(pclr),
    .waveform_output_in(wave), .high_cycles_out(high)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Whole run needs about 620 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; entering on a fresh edge keeps psel from being set twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    chk(n, 1, "access wait states");
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // Cycles between two pulses of bit b of {dma, overflow event}
  task gap(input int b, output int g);
    logic [4:0] v;
    int n;
    n = 0;
    g = 0;
    do begin
      @(posedge clk);
      v = {dma, ovf_ev};
      n++;
    end while (v[b] !== 1'b1 && n < 200);
    do begin
      @(posedge clk);
      v = {dma, ovf_ev};
      n++;
      g++;
    end while (v[b] !== 1'b1 && n < 400);
  endtask

  task t_reset;
    rd(`CWG_OFF_PERIOD);
    chk(q, 32'h0000ffff, "period reset");
    rd(8'h30);
    chk(e, 1'b1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    rd(8'h02);
    chk(e, 1'b1, "misaligned error");
  endtask

  task t_invert;
    wr(`CWG_OFF_DRV, 32'h5);
    repeat (3) @(posedge clk);
    chk(wave, 4'h5, "inverted idle outputs");
    wr(`CWG_OFF_DRV, 32'h0);
    repeat (3) @(posedge clk);
    chk(wave, 4'h0, "plain idle outputs");
  endtask

  task t_modes;
    int g;
    wr(`CWG_OFF_PERIOD, 32'h4);
    wr(`CWG_OFF_CC0, 32'h2);
    wr(`CWG_OFF_EVCTRL, 32'h1f);
    for (int i = 0; i < 9; i++) begin
      wr(`CWG_OFF_CTRL, 32'h0);
      wr(`CWG_OFF_PRESC, PS[i]);
      wr(`CWG_OFF_CTRL, (MD[i] << `CWG_CTRL_MODE_LO) | (DN[i] << `CWG_CTRL_DOWN) | 1);
      gap(0, g);
      chk(g, GP[i], "overflow spacing");
    end
    wr(`CWG_OFF_CTRL, 32'h0);
    wr(`CWG_OFF_PRESC, 32'h0);
  endtask

  task t_channels;
    int nd1, ne1, nd2, ne2, g;
    nd1 = 0;
    ne1 = 0;
    nd2 = 0;
    ne2 = 0;
    wr(`CWG_OFF_CC1, 32'h1);
    wr(`CWG_OFF_CC2, 32'h3);
    wr(`CWG_OFF_EVCTRL, 32'h05);
    wr(`CWG_OFF_CTRL, 32'h1);
    repeat (21) begin
      @(posedge clk);
      nd1 += dma[1];
      ne1 += mev[1];
      nd2 += dma[2];
      ne2 += mev[2];
      if (dma[1] === 1'b1) chk(cnt, 16'h0002, "flag a tick after match");
    end
    chk(nd1, 4, "channel 1 dma count");
    chk(nd2, 4, "channel 2 dma count");
    chk(ne1, 4, "enabled match events");
    chk(ne2, 0, "disabled match events");
    gap(3, g);
    chk(g, 5, "channel 2 spacing");
    wr(`CWG_OFF_CTRL, 32'h0);
  endtask

  // High time of one pad over 40 cycles, a whole number of periods of every case used
  task duty(input logic [31:0] ctl, input logic [31:0] inv, input int pin, input int exp);
    wr(`CWG_OFF_DRV, inv);
    wr(`CWG_OFF_CTRL, ctl);
    repeat (4) @(posedge clk);
    pclr <= 1'b1;
    @(posedge clk);
    pclr <= 1'b0;
    repeat (41) @(posedge clk);
    chk(high[pin], exp, "pad high time");
    wr(`CWG_OFF_CTRL, 32'h0);
    wr(`CWG_OFF_DRV, 32'h0);
  endtask

  task t_irq;
    wr(`CWG_OFF_PERIOD, 32'h4);
    wr(`CWG_OFF_INTMASK, 32'h02);
    wr(`CWG_OFF_CTRL, 32'h1);
    repeat (12) @(posedge clk);
    chk(irq, 1'b1, "unmasked match interrupt");
    wr(`CWG_OFF_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    rd(`CWG_OFF_INTSTAT);
    chk(q[1], 1'b1, "match flag");
    chk(q[0], 1'b1, "overflow flag");
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "interrupt after clear");
    rd(`CWG_OFF_INTSTAT);
    chk(q, 32'h0, "status after clear");
    wr(`CWG_OFF_INTMASK, 32'h0);
    wr(`CWG_OFF_CTRL, 32'h1);
    repeat (12) @(posedge clk);
    chk(irq, 1'b0, "masked match interrupt");
    wr(`CWG_OFF_CTRL, 32'h0);
    rd(`CWG_OFF_INTSTAT);
  endtask

  // Code 7 keeps the mode; a retrigger restarts the count and loads the buffered period
  task t_retrig;
    int n;
    wr(`CWG_OFF_CTRL, 32'h20);
    wr(`CWG_OFF_CTRL, 32'h70);
    rd(`CWG_OFF_CTRL);
    chk(q, 32'h20, "mode code 7 ignored");
    wr(`CWG_OFF_EVCTRL, 32'h1);
    wr(`CWG_OFF_INTMASK, 32'h1);
    wr(`CWG_OFF_PERIOD, 32'h64);
    wr(`CWG_OFF_CTRL, 32'h1);
    repeat (30) @(posedge clk);
    wr(`CWG_OFF_PERIOD, 32'h3);
    wr(`CWG_OFF_CTRL, 32'h201);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ovf_ev !== 1'b1 && n < 50);
    chk(n, 5, "overflow after retrigger");
    chk(irq, 1'b1, "unmasked overflow interrupt");
    wr(`CWG_OFF_CTRL, 32'h0);
    wr(`CWG_OFF_INTMASK, 32'h0);
    rd(`CWG_OFF_INTSTAT);
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    pa = 8'h00;
    pwd = 32'h0;
    pclr = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_invert;
    t_modes;
    t_channels;
    wr(`CWG_OFF_PERIOD, 32'h4);
    duty(32'h1, 32'h0, 0, 20);
    wr(`CWG_OFF_PERIOD, 32'h7);
    wr(`CWG_OFF_CC1, 32'h3);
    duty((CWG_NORMAL_PWM_MODE << `CWG_CTRL_MODE_LO) | 1, 32'h0, 1, 15);
    duty((CWG_NORMAL_PWM_MODE << `CWG_CTRL_MODE_LO) | 1, 32'h2, 1, 25);
    t_irq;
    t_retrig;
    give_verdict;
  end
endmodule
